// File: sfsw_top.sv
// Functional notes
// - status write keeps latch and busy bits
// - status write needs exactly 8 or 16 bits
// - select rise starts timed write: busy, then latch clears at end
// - status reads answered during timed write
// - lock bit with pin low rejects writes
// - otherwise quad and lock/protect bits writable
// - pin lock state lasts until pin high
// - quad or four-wire mode disables pin lock
// - protected region refuses program and erase
// - enter command sets wide flag, 32-bit addresses
// - wide mode ends by exit or reset
// - exit command clears wide flag, 24-bit addresses
// - address sampled rising, data shifted falling
// - read address increments per byte, wraps
// - fast read inserts dummy cycles, default 8
// - fast read ignored while write cycle runs
// - status layout lock,quad,protect,latch,busy
// - dummy select 00/01/10/11 gives 8/6/8/10
// - top/bottom bit one-time, default top
`timescale 1ns/1ps
`include "sfsw_params.svh"
module sfsw_top #(
  parameter int ARRAY_AW = 25,
  parameter int MEM_AW = 8,
  parameter int WRITE_CYCLES = `SFSW_STATUS_WRITE_CYCLES
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // serial link
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic SI,
  input wire logic IO_LINE_TWO_N,
  output logic SO,
  output logic SO_OE_N,
  // mode input
  input wire logic FOUR_WIRE_COMMAND_MODE,
  // program/erase request check
  input wire logic PE_REQ,
  input wire logic [31:0] PE_ADDR,
  input wire logic PE_ACTIVE,
  output logic PE_DENY,
  // array preload
  input wire logic ARRAY_WE,
  input wire logic [MEM_AW-1:0] ARRAY_WADDR,
  input wire logic [7:0] ARRAY_WDATA,
  // status view
  output logic [7:0] STATUS_REG,
  output logic [7:0] CONFIG_REG,
  output logic PIN_LOCK_STATE
);
  localparam logic [31:0] ADDR_MAX = 32'((64'h1 << ARRAY_AW) - 64'h1);
  localparam logic [15:0] WCYC = 16'(WRITE_CYCLES);

  sfsw_mem_if #(.AW(MEM_AW)) mif ();
  sfsw_mem #(.AW(MEM_AW)) u_mem (.clk(MCLK), .rst(RST), .bus(mif));

  function automatic logic [3:0] dummy_count(input logic [1:0] sel);
    case (sel)
      2'h0: dummy_count = `SFSW_DUMMY_00;
      2'h1: dummy_count = `SFSW_DUMMY_01;
      2'h2: dummy_count = `SFSW_DUMMY_10;
      default: dummy_count = `SFSW_DUMMY_11;
    endcase
  endfunction : dummy_count

  function automatic logic in_region(input logic [31:0] a, input logic [3:0] lvl,
    input logic bottom);
    logic [63:0] size;
    logic [31:0] off;
    size = 64'h0;
    off = a & ADDR_MAX;
    if (lvl != 4'h0)
    begin
      size = 64'h1 << (`SFSW_PROT_UNIT_BITS + 32'(lvl) - 1);
    end
    if (size > 64'(ADDR_MAX) + 64'h1)
    begin
      size = 64'(ADDR_MAX) + 64'h1;
    end
    if (bottom)
    begin
      in_region = 64'(off) < size;
    end
    else
    begin
      in_region = 64'(ADDR_MAX) - 64'(off) < size;
    end
  endfunction : in_region

  // pin synchronisers
  logic cs_s1, cs_s2, cs_s3, ck_s1, ck_s2, ck_s3, si_s1, si_s2, wp_s1, wp_s2;
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      {cs_s1, cs_s2, cs_s3} <= 3'h7;
      {ck_s1, ck_s2, ck_s3} <= 3'h0;
      {si_s1, si_s2} <= 2'h0;
      {wp_s1, wp_s2} <= 2'h3;
    end
    else
    begin
      {cs_s1, cs_s2, cs_s3} <= {CS_N, cs_s1, cs_s2};
      {ck_s1, ck_s2, ck_s3} <= {SCLK, ck_s1, ck_s2};
      {si_s1, si_s2} <= {SI, si_s1};
      {wp_s1, wp_s2} <= {IO_LINE_TWO_N, wp_s1};
    end
  end

  logic sck_rise, sck_fall, cs_rise;
  assign sck_rise = ck_s2 & ~ck_s3 & ~cs_s2;
  assign sck_fall = ~ck_s2 & ck_s3 & ~cs_s2;
  assign cs_rise = cs_s2 & ~cs_s3;

  // registers
  logic [7:0] status_q, config_q;
  logic [15:0] wcnt_q;
  logic busy_q;
  logic busy_flag;
  logic pin_lock;
  assign busy_flag = busy_q | PE_ACTIVE;
  assign pin_lock = status_q[`SFSW_SR_LOCK] & ~wp_s2 &
    ~status_q[`SFSW_SR_QE] & ~FOUR_WIRE_COMMAND_MODE;

  // command engine
  sfsw_pkg::sfsw_state_t state_q;
  sfsw_pkg::sfsw_src_t src_q;
  logic [7:0] op_q, in_q, out_q;
  logic [5:0] cnt_q;
  logic [2:0] obit_q;
  logic [15:0] wdata_q;
  logic [4:0] wbits_q;
  logic [31:0] addr_q;
  logic fast_q, pf_on_q;
  logic [7:0] opcode;
  logic [5:0] alen;
  logic [31:0] addr_shift;
  logic exec_wr;
  assign opcode = {in_q[6:0], si_s2};
  assign alen = config_q[`SFSW_CR_WIDE] ?
    `SFSW_ADDR_BITS_WIDE : `SFSW_ADDR_BITS_NARROW;
  assign addr_shift = {addr_q[30:0], si_s2};
  assign exec_wr = cs_rise && state_q == sfsw_pkg::ST_WDATA && status_q[`SFSW_SR_LATCH] &&
    !busy_flag && !pin_lock && (wbits_q == `SFSW_WR_BITS_ONE ||
    wbits_q == `SFSW_WR_BITS_TWO);

  // two-entry buffer between array and shifter
  logic [7:0] buf_q [0:1];
  logic [1:0] buf_cnt_q;
  logic buf_rd_q, buf_wr_q, inflight_q;
  logic buf_push, buf_pop, buf_ready;
  logic load_byte;
  assign load_byte = sck_fall && state_q == sfsw_pkg::ST_DATA && obit_q == 3'h0;
  assign buf_push = mif.rd_valid & pf_on_q;
  assign buf_pop = load_byte && src_q == sfsw_pkg::SRC_ARRAY && buf_cnt_q != 2'h0;
  assign buf_ready = (2'(buf_cnt_q) + 2'(inflight_q)) < 2'h2;

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      state_q <= sfsw_pkg::ST_IDLE;
      src_q <= sfsw_pkg::SRC_STATUS;
      op_q <= 8'h00;
      in_q <= 8'h00;
      cnt_q <= 6'h00;
      wdata_q <= 16'h0000;
      wbits_q <= 5'h00;
      addr_q <= 32'h0000_0000;
      fast_q <= 1'b0;
      pf_on_q <= 1'b0;
    end
    else if (cs_s2)
    begin
      state_q <= sfsw_pkg::ST_IDLE;
      pf_on_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        sfsw_pkg::ST_IDLE:
        begin
          state_q <= sfsw_pkg::ST_CMD;
          cnt_q <= 6'h00;
          wbits_q <= 5'h00;
        end
        sfsw_pkg::ST_CMD:
        begin
          if (sck_rise)
          begin
            in_q <= opcode;
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == 6'h07)
            begin
              op_q <= opcode;
              cnt_q <= 6'h00;
              fast_q <= opcode == `SFSW_OP_FAST_READ;
              case (opcode)
                `SFSW_OP_WRITE_UNLOCK, `SFSW_OP_ENTER_WIDE, `SFSW_OP_EXIT_WIDE:
                  state_q <= sfsw_pkg::ST_TAIL;
                `SFSW_OP_STATUS_WRITE:
                  state_q <= sfsw_pkg::ST_WDATA;
                `SFSW_OP_STATUS_READ:
                begin
                  state_q <= sfsw_pkg::ST_DATA;
                  src_q <= sfsw_pkg::SRC_STATUS;
                end
                `SFSW_OP_CONFIG_READ:
                begin
                  state_q <= sfsw_pkg::ST_DATA;
                  src_q <= sfsw_pkg::SRC_CONFIG;
                end
                `SFSW_OP_READ, `SFSW_OP_FAST_READ:
                begin
                  state_q <= busy_flag ? sfsw_pkg::ST_SKIP : sfsw_pkg::ST_ADDR;
                  src_q <= sfsw_pkg::SRC_ARRAY;
                end
                default:
                  state_q <= sfsw_pkg::ST_SKIP;
              endcase
            end
          end
        end
        sfsw_pkg::ST_ADDR:
        begin
          if (sck_rise)
          begin
            addr_q <= addr_shift;
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == alen - 6'h01)
            begin
              addr_q <= addr_shift & ADDR_MAX;
              cnt_q <= 6'h00;
              pf_on_q <= 1'b1;
              state_q <= fast_q ? sfsw_pkg::ST_DUMMY : sfsw_pkg::ST_DATA;
            end
          end
        end
        sfsw_pkg::ST_DUMMY:
        begin
          if (sck_rise)
          begin
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == 6'(dummy_count(config_q[`SFSW_CR_DC_HI:`SFSW_CR_DC_LO])) - 6'h01)
            begin
              state_q <= sfsw_pkg::ST_DATA;
            end
          end
        end
        sfsw_pkg::ST_WDATA:
        begin
          if (sck_rise)
          begin
            wdata_q <= {wdata_q[14:0], si_s2};
            if (wbits_q != 5'h11)
            begin
              wbits_q <= wbits_q + 5'h01;
            end
          end
        end
        sfsw_pkg::ST_TAIL:
        begin
          if (sck_rise)
          begin
            state_q <= sfsw_pkg::ST_SKIP;
          end
        end
        sfsw_pkg::ST_DATA, sfsw_pkg::ST_SKIP:
        begin
          state_q <= state_q;
        end
        default:
          state_q <= sfsw_pkg::ST_IDLE;
      endcase
      if (mif.rd_en)
      begin
        addr_q <= (addr_q == ADDR_MAX) ? 32'h0000_0000 : addr_q + 32'h1;
      end
    end
  end

  // status and configuration registers, self-timed write
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      status_q <= `SFSW_SR_RESET;
      config_q <= `SFSW_CR_RESET;
      busy_q <= 1'b0;
      wcnt_q <= 16'h0000;
    end
    else
    begin
      if (exec_wr)
      begin
        status_q[`SFSW_SR_LOCK:`SFSW_SR_BP_LO] <= wbits_q == `SFSW_WR_BITS_TWO ?
          wdata_q[15:10] : wdata_q[7:2];
        if (wbits_q == `SFSW_WR_BITS_TWO)
        begin
          config_q[`SFSW_CR_DC_HI:`SFSW_CR_DC_LO] <= wdata_q[7:6];
          config_q[`SFSW_CR_TB] <= config_q[`SFSW_CR_TB] | wdata_q[3];
          config_q[`SFSW_CR_ODS_HI:0] <= wdata_q[2:0];
        end
        busy_q <= 1'b1;
        wcnt_q <= WCYC;
      end
      else if (busy_q)
      begin
        wcnt_q <= wcnt_q - 16'h1;
        if (wcnt_q == 16'h1)
        begin
          busy_q <= 1'b0;
          status_q[`SFSW_SR_LATCH] <= 1'b0;
        end
      end
      if (cs_rise && state_q == sfsw_pkg::ST_TAIL && !busy_flag)
      begin
        case (op_q)
          `SFSW_OP_WRITE_UNLOCK: status_q[`SFSW_SR_LATCH] <= 1'b1;
          `SFSW_OP_ENTER_WIDE: config_q[`SFSW_CR_WIDE] <= 1'b1;
          `SFSW_OP_EXIT_WIDE: config_q[`SFSW_CR_WIDE] <= 1'b0;
          default: config_q <= config_q;
        endcase
      end
    end
  end

  // buffer fill and drain
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      buf_q[0] <= 8'h00;
      buf_q[1] <= 8'h00;
      buf_cnt_q <= 2'h0;
      buf_rd_q <= 1'b0;
      buf_wr_q <= 1'b0;
      inflight_q <= 1'b0;
    end
    else if (!pf_on_q)
    begin
      buf_cnt_q <= 2'h0;
      buf_rd_q <= 1'b0;
      buf_wr_q <= 1'b0;
      inflight_q <= 1'b0;
    end
    else
    begin
      inflight_q <= mif.rd_en;
      if (buf_push)
      begin
        buf_q[buf_wr_q] <= mif.rd_data;
        buf_wr_q <= ~buf_wr_q;
      end
      if (buf_pop)
      begin
        buf_rd_q <= ~buf_rd_q;
      end
      buf_cnt_q <= buf_cnt_q + 2'(buf_push) - 2'(buf_pop);
    end
  end

  assign mif.rd_en = pf_on_q & buf_ready & ~cs_s2;
  assign mif.rd_addr = addr_q[MEM_AW-1:0];
  assign mif.wr_en = ARRAY_WE;
  assign mif.wr_addr = ARRAY_WADDR;
  assign mif.wr_data = ARRAY_WDATA;

  // output shifter and status view
  logic [7:0] next_byte;
  always_comb
  begin
    case (src_q)
      sfsw_pkg::SRC_STATUS: next_byte = {status_q[7:1], busy_flag};
      sfsw_pkg::SRC_CONFIG: next_byte = config_q;
      default: next_byte = buf_cnt_q != 2'h0 ? buf_q[buf_rd_q] : 8'h00;
    endcase
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      out_q <= 8'h00;
      obit_q <= 3'h0;
      SO <= 1'b0;
      SO_OE_N <= 1'b1;
      PE_DENY <= 1'b0;
      STATUS_REG <= `SFSW_SR_RESET;
      CONFIG_REG <= `SFSW_CR_RESET;
      PIN_LOCK_STATE <= 1'b0;
    end
    else
    begin
      SO_OE_N <= ~(state_q == sfsw_pkg::ST_DATA && !cs_s2);
      if (cs_s2)
      begin
        obit_q <= 3'h0;
      end
      else if (sck_fall && state_q == sfsw_pkg::ST_DATA)
      begin
        obit_q <= obit_q + 3'h1;
        if (load_byte)
        begin
          SO <= next_byte[7];
          out_q <= {next_byte[6:0], 1'b0};
        end
        else
        begin
          SO <= out_q[7];
          out_q <= {out_q[6:0], 1'b0};
        end
      end
      PE_DENY <= PE_REQ & in_region(PE_ADDR, status_q[`SFSW_SR_BP_HI:`SFSW_SR_BP_LO],
        config_q[`SFSW_CR_TB]);
      STATUS_REG <= {status_q[7:1], busy_flag};
      CONFIG_REG <= config_q;
      PIN_LOCK_STATE <= pin_lock;
    end
  end
endmodule : sfsw_top

// File: sfsw_params.svh
`ifndef SFSW_PARAMS_SVH
`define SFSW_PARAMS_SVH

// command opcodes
`define SFSW_OP_WRITE_UNLOCK 8'h06
`define SFSW_OP_STATUS_WRITE 8'h01
`define SFSW_OP_STATUS_READ 8'h05
`define SFSW_OP_CONFIG_READ 8'h15
`define SFSW_OP_ENTER_WIDE 8'hb7
`define SFSW_OP_EXIT_WIDE 8'he9
`define SFSW_OP_READ 8'h03
`define SFSW_OP_FAST_READ 8'h0b

// status register fields
`define SFSW_SR_LOCK 7
`define SFSW_SR_QE 6
`define SFSW_SR_BP_HI 5
`define SFSW_SR_BP_LO 2
`define SFSW_SR_LATCH 1
`define SFSW_SR_BUSY 0
`define SFSW_SR_RESET 8'h00

// configuration register fields
`define SFSW_CR_DC_HI 7
`define SFSW_CR_DC_LO 6
`define SFSW_CR_WIDE 5
`define SFSW_CR_TB 3
`define SFSW_CR_ODS_HI 2
`define SFSW_CR_RESET 8'h07

// address phase lengths in bits
`define SFSW_ADDR_BITS_NARROW 6'h18
`define SFSW_ADDR_BITS_WIDE 6'h20

// data bit counts accepted by a status write
`define SFSW_WR_BITS_ONE 5'h08
`define SFSW_WR_BITS_TWO 5'h10

// dummy cycle counts per dummy select code
`define SFSW_DUMMY_00 4'h8
`define SFSW_DUMMY_01 4'h6
`define SFSW_DUMMY_10 4'h8
`define SFSW_DUMMY_11 4'ha

// self-timed status write time and its cycle count at 4 ns per clock
`define SFSW_STATUS_WRITE_TIME_NS 10000
`define SFSW_CLK_PERIOD_NS 4
`define SFSW_STATUS_WRITE_CYCLES \
  ((`SFSW_STATUS_WRITE_TIME_NS + `SFSW_CLK_PERIOD_NS - 1) / `SFSW_CLK_PERIOD_NS)

// smallest protected unit: 64 KiB expressed as address bits
`define SFSW_PROT_UNIT_BITS 16

`endif

// File: sfsw_pkg.sv
package sfsw_pkg;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_CMD   = 8'h02,
    ST_ADDR  = 8'h04,
    ST_DUMMY = 8'h08,
    ST_DATA  = 8'h10,
    ST_WDATA = 8'h20,
    ST_TAIL  = 8'h40,
    ST_SKIP  = 8'h80
  } sfsw_state_t;

  typedef enum logic [1:0] {
    SRC_STATUS = 2'h0,
    SRC_CONFIG = 2'h1,
    SRC_ARRAY  = 2'h2
  } sfsw_src_t;

endpackage : sfsw_pkg

// File: sfsw_mem_if.sv
`timescale 1ns/1ps
interface sfsw_mem_if #(parameter int AW = 8);
  logic rd_en;
  logic [AW-1:0] rd_addr;
  logic [7:0] rd_data;
  logic rd_valid;
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [7:0] wr_data;

  modport ctrl (output rd_en, output rd_addr, input rd_data, input rd_valid,
    output wr_en, output wr_addr, output wr_data);
  modport mem (input rd_en, input rd_addr, output rd_data, output rd_valid,
    input wr_en, input wr_addr, input wr_data);
endinterface : sfsw_mem_if

// File: sfsw_mem.sv
`timescale 1ns/1ps
module sfsw_mem #(
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic rst,
  sfsw_mem_if.mem bus
);
  logic [7:0] cell_q [0:(1<<AW)-1];
  logic [7:0] rd_data_q;
  logic rd_valid_q;

  always_ff @(posedge clk)
  begin
    if (bus.wr_en)
    begin
      cell_q[bus.wr_addr] <= bus.wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= bus.rd_en;
      if (bus.rd_en)
      begin
        rd_data_q <= cell_q[bus.rd_addr];
      end
    end
  end

  assign bus.rd_data = rd_data_q;
  assign bus.rd_valid = rd_valid_q;
endmodule : sfsw_mem

// File: sfsw_host_model.sv
`timescale 1ns/1ps
module sfsw_host (
  // serial link
  output logic cs_n,
  output logic sclk,
  output logic si,
  input wire logic so
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  task start;
    cs_n = 1'b0;
    #32;
  endtask : start
  // data moves while the clock is low, the reply is taken at the rise
  task bit1(input logic b, output logic r);
    si = b;
    #32;
    sclk = 1'b1;
    r = so;
    #32;
    sclk = 1'b0;
  endtask : bit1
  task byte8(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) bit1(b[i], r[i]);
  endtask : byte8
  task stop;
    #32;
    cs_n = 1'b1;
    si = ~si;
    #64;
  endtask : stop
endmodule : sfsw_host

// File: sfsw_properties.sv
`timescale 1ns/1ps
module sfsw_properties (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // link
  input wire logic CS_N,
  input wire logic IO_LINE_TWO_N,
  input wire logic SO_OE_N,
  // mode and program/erase check
  input wire logic FOUR_WIRE_COMMAND_MODE,
  input wire logic PE_REQ,
  input wire logic PE_ACTIVE,
  input wire logic PE_DENY,
  // status view
  input wire logic [7:0] STATUS_REG,
  input wire logic [7:0] CONFIG_REG,
  input wire logic PIN_LOCK_STATE
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  a_oe_idle_off: assert property (CS_N [*8] |-> SO_OE_N)
    else $error("output driven while deselected");
  a_busy_holds: assert property ($rose(STATUS_REG[0]) && !PE_ACTIVE |-> STATUS_REG[0] [*8])
    else $error("busy too short");
  a_latch_at_end: assert property ($fell(STATUS_REG[0]) && !$past(PE_ACTIVE)
    && !$past(PE_ACTIVE, 3) |-> ##[0:2] !STATUS_REG[1])
    else $error("latch kept after write");
  a_deny_cause: assert property (PE_DENY |-> $past(PE_REQ))
    else $error("deny without request");
  a_deny_unprot: assert property (PE_REQ && STATUS_REG[5:2] == 4'h0 && $stable(STATUS_REG)
    |=> !PE_DENY)
    else $error("deny with no protection");
  a_lock_needs_bit: assert property (PIN_LOCK_STATE |-> STATUS_REG[7] && !STATUS_REG[6])
    else $error("pin lock without lock bit");
  a_four_wire_free: assert property (FOUR_WIRE_COMMAND_MODE [*2] |-> !PIN_LOCK_STATE)
    else $error("pin lock in four wire mode");
  a_pin_high_free: assert property (IO_LINE_TWO_N [*6] |-> !PIN_LOCK_STATE)
    else $error("pin lock with pin high");
  a_wide_at_end: assert property ($changed(CONFIG_REG[5]) |-> CS_N && $past(CS_N))
    else $error("wide flag changed mid frame");
  a_status_at_end: assert property ($changed(STATUS_REG[7:2]) |-> CS_N)
    else $error("status changed mid frame");
endmodule : sfsw_properties
bind sfsw_top sfsw_properties i_props (.MCLK(MCLK), .RST(RST), .CS_N(CS_N),
  .IO_LINE_TWO_N(IO_LINE_TWO_N), .SO_OE_N(SO_OE_N),
  .FOUR_WIRE_COMMAND_MODE(FOUR_WIRE_COMMAND_MODE), .PE_REQ(PE_REQ),
  .PE_ACTIVE(PE_ACTIVE), .PE_DENY(PE_DENY), .STATUS_REG(STATUS_REG),
  .CONFIG_REG(CONFIG_REG), .PIN_LOCK_STATE(PIN_LOCK_STATE));

// File: tb_serial_flash_status_write_and_read.sv
`timescale 1ns/1ps
`include "sfsw_params.svh"
module tb_serial_flash_status_write_and_read;
  localparam int WC = 600;
  logic mclk, rst, cs_n, sclk, si, so, so_oe_n, wp_n, four_wire;
  logic pe_req, pe_active, pe_deny, pin_lock, array_we, oe_seen;
  logic [31:0] pe_addr;
  logic [7:0] array_waddr, array_wdata, status_reg, config_reg, q;
  logic [7:0] d [0:3];
  logic [3:0] dummy [0:3];
  int num_errors, cmp_count;
  sfsw_top #(.WRITE_CYCLES(WC)) i_dut (.MCLK(mclk), .RST(rst), .CS_N(cs_n), .SCLK(sclk),
    .SI(si), .IO_LINE_TWO_N(wp_n), .SO(so), .SO_OE_N(so_oe_n),
    .FOUR_WIRE_COMMAND_MODE(four_wire), .PE_REQ(pe_req), .PE_ADDR(pe_addr),
    .PE_ACTIVE(pe_active), .PE_DENY(pe_deny), .ARRAY_WE(array_we),
    .ARRAY_WADDR(array_waddr), .ARRAY_WDATA(array_wdata), .STATUS_REG(status_reg),
    .CONFIG_REG(config_reg), .PIN_LOCK_STATE(pin_lock));
  // a released output line reads back inverted
  sfsw_host i_host (.cs_n(cs_n), .sclk(sclk), .si(si), .so(so_oe_n ? ~so : so));
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk)
    if (so_oe_n === 1'b0) oe_seen <= 1'b1;
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'h5a;
  endfunction : pat
  task cmd1(input logic [7:0] op);
    i_host.start();
    i_host.byte8(op, q);
    i_host.stop();
  endtask : cmd1
  task sr_write(input logic [7:0] s, input logic [7:0] c, input bit two);
    cmd1(`SFSW_OP_WRITE_UNLOCK);
    i_host.start();
    i_host.byte8(`SFSW_OP_STATUS_WRITE, q);
    i_host.byte8(s, q);
    if (two) i_host.byte8(c, q);
    i_host.stop();
  endtask : sr_write
  task wait_idle;
    for (int i = 0; i < 2 * WC && status_reg[0] !== 1'b0; i++) tick(1);
  endtask : wait_idle
  task rd(input logic [7:0] op, input logic [31:0] a, input int na, input int nd, input int nb);
    i_host.start();
    i_host.byte8(op, q);
    for (int i = na - 1; i >= 0; i--) i_host.byte8(a[8*i +: 8], q);
    repeat (nd) i_host.bit1(1'b0, q[0]);
    for (int i = 0; i < nb; i++) i_host.byte8(8'h00, d[i]);
    i_host.stop();
  endtask : rd
  task t_status_write;
    i_host.start();
    i_host.byte8(`SFSW_OP_STATUS_WRITE, q);
    i_host.byte8(8'h9f, q);
    i_host.stop();
    tick(20);
    check(status_reg, 8'h00);
    sr_write(8'h9f, 8'h00, 1'b0);
    rd(`SFSW_OP_STATUS_READ, 0, 0, 0, 1);
    check(d[0], 8'h9f);
    wait_idle();
    check(status_reg, 8'h9c);
    cmd1(`SFSW_OP_WRITE_UNLOCK);
    i_host.start();
    i_host.byte8(`SFSW_OP_STATUS_WRITE, q);
    i_host.byte8(8'h80, q);
    i_host.bit1(1'b1, q[0]);
    i_host.stop();
    tick(20);
    check(status_reg, 8'h9e);
    sr_write(8'h9c, 8'h48, 1'b1);
    wait_idle();
    check(config_reg & 8'hef, 8'h48);
    rd(`SFSW_OP_CONFIG_READ, 0, 0, 0, 1);
    check(d[0], 8'h48);
  endtask : t_status_write
  task t_pin_lock;
    wp_n = 1'b0;
    tick(8);
    check({7'h00, pin_lock}, 8'h01);
    sr_write(8'h00, 8'h00, 1'b0);
    tick(20);
    check(status_reg & 8'hfc, 8'h9c);
    four_wire = 1'b1;
    tick(4);
    check({7'h00, pin_lock}, 8'h00);
    four_wire = 1'b0;
    tick(8);
    check({7'h00, pin_lock}, 8'h01);
    wp_n = 1'b1;
    tick(8);
    check({7'h00, pin_lock}, 8'h00);
    sr_write(8'hc4, 8'h00, 1'b0);
    wait_idle();
    check(status_reg, 8'hc4);
    wp_n = 1'b0;
    tick(8);
    check({7'h00, pin_lock}, 8'h00);
    sr_write(8'h04, 8'h00, 1'b0);
    wait_idle();
    check(status_reg, 8'h04);
    wp_n = 1'b1;
  endtask : t_pin_lock
  task t_read;
    cmd1(`SFSW_OP_ENTER_WIDE);
    tick(8);
    check(config_reg & 8'h20, 8'h20);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(4);
    check(config_reg, `SFSW_CR_RESET);
    cmd1(`SFSW_OP_ENTER_WIDE);
    tick(8);
    rd(`SFSW_OP_READ, 32'h01ffffff, 4, 0, 2);
    check(d[0], pat(8'hff));
    check(d[1], pat(8'h00));
    cmd1(`SFSW_OP_EXIT_WIDE);
    tick(8);
    check(config_reg & 8'h20, 8'h00);
    rd(`SFSW_OP_READ, 32'h0000fe, 3, 0, 2);
    check(d[0], pat(8'hfe));
    check(d[1], pat(8'hff));
  endtask : t_read
  task t_fast;
    for (int c = 0; c < 4; c++)
    begin
      sr_write(8'h04, {c[1:0], 6'h0f}, 1'b1);
      wait_idle();
      rd(`SFSW_OP_FAST_READ, 32'h10 + c, 3, dummy[c], 1);
      check(d[0], pat(8'h10 + c[7:0]));
    end
  endtask : t_fast
  task t_busy;
    pe_active = 1'b1;
    tick(4);
    oe_seen = 1'b0;
    rd(`SFSW_OP_FAST_READ, 32'h20, 3, dummy[3], 1);
    check({7'h00, oe_seen}, 8'h00);
    pe_active = 1'b0;
    tick(4);
    check({7'h00, status_reg[0]}, 8'h00);
    pe_addr = 32'h0000ffff;
    pe_req = 1'b1;
    tick(1);
    check({7'h00, pe_deny}, 8'h01);
    pe_addr = 32'h00010000;
    tick(1);
    check({7'h00, pe_deny}, 8'h00);
    pe_req = 1'b0;
  endtask : t_busy
  task t_reset;
    tick(4);
    check(status_reg, `SFSW_SR_RESET);
    check(config_reg, `SFSW_CR_RESET);
    check({6'h00, pin_lock, so_oe_n}, 8'h01);
    {pe_req, pe_addr} = {1'b1, 32'h01ff0000};
    tick(2);
    check({7'h00, pe_deny}, 8'h00);
    pe_req = 1'b0;
    for (int i = 0; i < 256; i++)
    begin
      {array_we, array_waddr, array_wdata} = {1'b1, i[7:0], pat(i[7:0])};
      tick(1);
    end
    array_we = 1'b0;
  endtask : t_reset
  task summarize;
    $display("mismatches %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  initial
  begin
    #200000;
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    summarize();
  end
  initial
  begin
    rst = 1'b1;
    {wp_n, four_wire, pe_req, pe_active, array_we, oe_seen} = 6'h20;
    {pe_addr, array_waddr, array_wdata} = '0;
    dummy = '{`SFSW_DUMMY_00, `SFSW_DUMMY_01, `SFSW_DUMMY_10, `SFSW_DUMMY_11};
    repeat (12) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_reset();
    $display("reset test done");
    t_status_write();
    $display("status write test done");
    t_pin_lock();
    $display("pin lock test done");
    t_read();
    $display("read test done");
    t_fast();
    $display("fast read test done");
    t_busy();
    $display("busy test done");
    summarize();
  end
endmodule : tb_serial_flash_status_write_and_read
